// file: pkg/nib_stream_if.sv
/*
  Valid/ready nibble stream between the latency core and its buffer.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface nib_stream_if #(parameter int W = 4);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: pkg/phy_lat_pkg.sv
/*
  Constants for the transceiver latency block: clock rate, bit-time
  lengths, latency figures in bit times and pipeline offsets.
  Assumes a single 10 MHz core clock; the core, the MAC model and the bench import it.
*/
`default_nettype none

package phy_lat_pkg;

  // Core clock and bit times
  localparam int CLK_PERIOD_NS = 100;
  localparam int BT_100M_NS    = 10;
  localparam int BT_10M_NS     = 100;
  // Least times round up, never below one cycle
  localparam int BT_100M_RAW   = (BT_100M_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int BT_10M_RAW    = (BT_10M_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [3:0] BT_CYC_100M = (BT_100M_RAW < 1) ? 4'h1
                                       : 4'(BT_100M_RAW);
  localparam logic [3:0] BT_CYC_10M  = (BT_10M_RAW < 1) ? 4'h1
                                       : 4'(BT_10M_RAW);

  // Latency figures in bit times
  localparam int TX_J_BT      = 12;
  localparam int CRS_ON_BT    = 16;
  localparam int CRS_OFF_BT   = 23;
  localparam int COL_ON_BT    = 20;
  localparam int COL_OFF_BT   = 24;
  localparam int LOOP_CRS_BT  = 6;
  localparam int TX10_MAX_BT  = 6;
  localparam int RX10_MAX_BT  = 6;

  // Fixed pipeline outside the history taps
  localparam int TX_PIPE      = 1;
  localparam int LINE_PIPE    = 3;  // Two sync flops plus output flop

  // History lengths and taps
  localparam int TX_HIST      = TX_J_BT + 1;
  localparam int LINE_HIST    = COL_OFF_BT - LINE_PIPE + 1;
  localparam int TAP_TX_J     = TX_J_BT - TX_PIPE;
  localparam int TAP_LOOP     = LOOP_CRS_BT - TX_PIPE;
  localparam int TAP_CRS_ON   = CRS_ON_BT - LINE_PIPE;
  localparam int TAP_CRS_OFF  = CRS_OFF_BT - LINE_PIPE;
  localparam int TAP_COL_ON   = COL_ON_BT - LINE_PIPE;
  localparam int TAP_COL_OFF  = COL_OFF_BT - LINE_PIPE;

  // Transmit nibble buffer
  localparam int NIB_W        = 4;
  localparam int FIFO_DEPTH   = 4;
  localparam logic [2:0] NIB_LAST = 3'h3;

endpackage

`default_nettype wire

// file: src/nib_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset; ready on the
  filling side comes straight from a register.
*/
`default_nettype none

module nib_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 4
) (
  input  wire logic   clk,
  input  wire logic   rst,
  nib_stream_if.snk   up,
  nib_stream_if.src   dn
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          room;
  } fifo_st_t;

  fifo_st_t     st;
  fifo_st_t     next_st;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign push     = up.valid && st.room;
  assign pop      = dn.ready && (st.cnt != '0);
  assign up.ready = st.room;
  assign dn.valid = (st.cnt != '0);
  assign dn.data  = mem[st.rp];

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = (st.wp == LAST_PTR) ? '0 : st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST_PTR) ? '0 : st.rp + AW'(1);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - (AW+1)'(1);
    end
    next_st.room = (next_st.cnt != FULL_CNT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{wp: '0, rp: '0, cnt: '0, room: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // Storage, written on accepted pushes only
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp] <= up.data;
    end
  end

endmodule

`default_nettype wire

// file: src/phy_mii_line_latency.sv
/*
  Timing core of a dual-speed transceiver between the MII and the line.
  Generates the line start-delimiter strobe, carrier sense, collision,
  the 10 Mb/s serial transmit bit and the 10 Mb/s receive nibbles with
  fixed latencies counted in bit times.
  Assumes MII inputs come from logic on clk; line and strap pins are
  asynchronous and are synchronised here. Line delimiter inputs are
  one-bit-time pulses marking the first bit of J or T.
*/
`default_nettype none

// How it works
// - At 100 Mb/s the J strobe goes out 12 bit times after tx_en is first sampled high.
// - At 100 Mb/s carrier sense rises 16 bit times after a J arrives on the line.
// - At 100 Mb/s carrier sense falls 23 bit times after a T arrives on the line.
// - At 100 Mb/s collision rises 20 bit times after a J if a collision exists.
// - At 100 Mb/s collision falls 24 bit times after a T arrives on the line.
// - With repeater mode low, carrier sense rises 6 bit times after tx_en rises.
// - With repeater mode low, carrier sense falls 6 bit times after tx_en falls.
// - At 10 Mb/s the first transmit bit reaches the line output within 6 bit times of tx_en.
// - At 10 Mb/s received bits reach the MII nibble lines within 6 bit times.
module phy_mii_line_latency
  import phy_lat_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             speed_100,
  input  wire logic             repeater_mode_select,
  input  wire logic             tx_en,
  input  wire logic [NIB_W-1:0] txd,
  output wire logic             tx_ready,
  input  wire logic             line_rx_j,
  input  wire logic             line_rx_t,
  input  wire logic             line_collision,
  input  wire logic             line_rx_carrier,
  input  wire logic             twisted_pair_rx_in,
  output logic                  line_tx_j,
  output logic                  twisted_pair_tx_out,
  output logic                  twisted_pair_tx_active,
  output logic                  crs,
  output logic                  col,
  output logic [NIB_W-1:0]      rxd,
  output logic                  rx_dv
);

  typedef struct packed {
    logic [1:0]           spd_s;
    logic [1:0]           repeater_mode_select_s;
    logic [1:0]           j_s;
    logic [1:0]           t_s;
    logic [1:0]           col_s;
    logic [1:0]           car_s;
    logic [1:0]           rd_s;
    logic [3:0]           div;
    logic [TX_HIST-1:0]   tx_h;
    logic [LINE_HIST-1:0] j_h;
    logic [LINE_HIST-1:0] t_h;
    logic                 crs_line;
    logic                 col_line;
    logic [NIB_W-1:0]     tx_sh;
    logic [2:0]           tx_n;
    logic [NIB_W-1:0]     rx_sh;
    logic [1:0]           rx_n;
    logic                 line_tx_j;
    logic                 tp_out;
    logic                 tp_active;
    logic                 crs;
    logic                 col;
    logic [NIB_W-1:0]     rxd;
    logic                 rx_dv;
  } core_st_t;

  core_st_t st;
  core_st_t next_st;
  logic     bt_tick;
  logic     fast;
  logic     loop_on;

  nib_stream_if #(.W(NIB_W)) up_if ();
  nib_stream_if #(.W(NIB_W)) dn_if ();

  // Transmit nibbles wait here at 10 Mb/s; MAC stalls on tx_ready
  nib_fifo #(.W(NIB_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk (clk),
    .rst (rst),
    .up  (up_if.snk),
    .dn  (dn_if.src)
  );

  assign fast        = st.spd_s[1];
  assign loop_on     = !st.repeater_mode_select_s[1];
  assign bt_tick     = (st.div == 4'h0);
  assign up_if.valid = tx_en && !fast;
  assign up_if.data  = txd;
  assign dn_if.ready = !fast && bt_tick && (st.tx_n == 3'h0);
  assign tx_ready    = up_if.ready;

  // Next state of the whole core
  always_comb begin
    next_st = st;
    // Two-stage synchronisers for pins
    next_st.spd_s  = {st.spd_s[0], speed_100};
    next_st.repeater_mode_select_s = {st.repeater_mode_select_s[0], repeater_mode_select};
    next_st.j_s    = {st.j_s[0], line_rx_j};
    next_st.t_s    = {st.t_s[0], line_rx_t};
    next_st.col_s  = {st.col_s[0], line_collision};
    next_st.car_s  = {st.car_s[0], line_rx_carrier};
    next_st.rd_s   = {st.rd_s[0], twisted_pair_rx_in};
    // Bit-time divider reloads per active rate
    if (bt_tick) begin
      next_st.div = (fast ? BT_CYC_100M : BT_CYC_10M) - 4'h1;
    end else begin
      next_st.div = st.div - 4'h1;
    end
    next_st.line_tx_j = 1'b0;
    if (bt_tick) begin
      // Event histories, one step per bit time
      next_st.tx_h = {st.tx_h[TX_HIST-2:0], tx_en};
      next_st.j_h  = {st.j_h[LINE_HIST-2:0], st.j_s[1]};
      next_st.t_h  = {st.t_h[LINE_HIST-2:0], st.t_s[1]};
      if (fast) begin
        // J strobe on the rising edge of delayed tx_en
        next_st.line_tx_j = st.tx_h[TAP_TX_J]
                            && !st.tx_h[TAP_TX_J+1];
        if (st.j_h[TAP_CRS_ON]) begin
          next_st.crs_line = 1'b1;
        end else if (st.t_h[TAP_CRS_OFF]) begin
          next_st.crs_line = 1'b0;
        end
        if (st.j_h[TAP_COL_ON] && st.col_s[1]) begin
          next_st.col_line = 1'b1;
        end else if (st.t_h[TAP_COL_OFF]) begin
          next_st.col_line = 1'b0;
        end
        next_st.crs = next_st.crs_line
                      || (loop_on && st.tx_h[TAP_LOOP]);
        next_st.col = next_st.col_line;
      end else begin
        next_st.crs_line = 1'b0;
        next_st.col_line = 1'b0;
        next_st.crs = st.car_s[1]
                      || (loop_on && st.tx_h[TAP_LOOP]);
        next_st.col = st.col_s[1];
      end
    end
    // 10 Mb/s serial transmit, low bit first
    if (!fast && bt_tick) begin
      if (dn_if.valid && dn_if.ready) begin
        next_st.tp_out    = dn_if.data[0];
        next_st.tx_sh     = dn_if.data >> 1;
        next_st.tx_n      = NIB_LAST;
        next_st.tp_active = 1'b1;
      end else if (st.tx_n != 3'h0) begin
        next_st.tp_out    = st.tx_sh[0];
        next_st.tx_sh     = st.tx_sh >> 1;
        next_st.tx_n      = st.tx_n - 3'h1;
      end else begin
        next_st.tp_out    = 1'b0;
        next_st.tp_active = 1'b0;
      end
    end else if (fast) begin
      next_st.tp_out    = 1'b0;
      next_st.tp_active = 1'b0;
      next_st.tx_n      = 3'h0;
    end
    // 10 Mb/s receive, low bit first into nibbles
    if (fast || !st.car_s[1]) begin
      next_st.rx_n  = 2'h0;
      next_st.rx_dv = 1'b0;
      next_st.rxd   = '0;
    end else if (bt_tick) begin
      next_st.rx_sh = {st.rd_s[1], st.rx_sh[NIB_W-1:1]};
      next_st.rx_n  = st.rx_n + 2'h1;
      if (st.rx_n == 2'h3) begin
        next_st.rxd   = {st.rd_s[1], st.rx_sh[NIB_W-1:1]};
        next_st.rx_dv = 1'b1;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign line_tx_j              = st.line_tx_j;
  assign twisted_pair_tx_out    = st.tp_out;
  assign twisted_pair_tx_active = st.tp_active;
  assign crs                    = st.crs;
  assign col                    = st.col;
  assign rxd                    = st.rxd;
  assign rx_dv                  = st.rx_dv;

endmodule

`default_nettype wire

// file: verif/mac_model.sv
/*
  MAC side model: drives transmit enable and nibbles.
  Assumes tx_ready is settled by the falling clock edge.
*/
`default_nettype none

module mac_model
  import phy_lat_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             tx_ready,
  output var  logic             tx_en,
  output var  logic [NIB_W-1:0] txd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    tx_en = 1'b0;
    txd   = 4'h5;
  end

  // Frame of n nibbles, each held until taken; call at a rising edge
  task automatic frame(input int n, input logic [NIB_W-1:0] d0);
    int   i;
    logic rdy;
    i = 0;
    while (i < n) begin
      tx_en <= 1'b1;
      txd   <= d0 + NIB_W'(i);
      @(negedge clk);
      rdy = tx_ready;
      @(posedge clk);
      if (rdy) i++;
    end
    tx_en <= 1'b0;
    txd   <= ~txd;
  endtask
endmodule

`default_nettype wire

// file: verif/phy_mii_line_latency_bench.sv
/*
  Self-checking bench for the transceiver timing core.
  Assumes a 10 MHz clock and one bit time per clock cycle.
*/
`default_nettype none

module phy_mii_line_latency_bench
  import phy_lat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, speed_100, repeater_mode_select, tx_en, tx_ready;
  logic line_rx_j, line_rx_t, line_collision, line_rx_carrier;
  logic twisted_pair_rx_in, line_tx_j, twisted_pair_tx_out, saw_full;
  logic twisted_pair_tx_active, crs, col, rx_dv;
  logic [NIB_W-1:0] txd, rxd;
  logic [4:0]       mon, prev;
  logic             bits[$];
  int               rise[5], fall[5];
  int               cyc = 0, errors = 0, checks_done = 0, t0, t1;

  phy_mii_line_latency dut (
    .clk, .rst, .speed_100, .repeater_mode_select, .tx_en, .txd,
    .tx_ready, .line_rx_j, .line_rx_t, .line_collision,
    .line_rx_carrier, .twisted_pair_rx_in, .line_tx_j,
    .twisted_pair_tx_out, .twisted_pair_tx_active, .crs, .col,
    .rxd, .rx_dv
  );
  mac_model mac (.clk, .tx_ready, .tx_en, .txd);

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Edge times of outputs, serial bits, full flag
  assign mon = {twisted_pair_tx_active, rx_dv, col, crs, line_tx_j};
  always @(negedge clk) begin
    for (int k = 0; k < 5; k++) begin
      if (mon[k] === 1'b1 && prev[k] !== 1'b1) rise[k] = cyc;
      if (mon[k] === 1'b0 && prev[k] === 1'b1) fall[k] = cyc;
    end
    prev = mon;
    if (mon[4] === 1'b1) bits.push_back(twisted_pair_tx_out);
    if (tx_ready === 1'b0) saw_full = 1'b1;
  end

  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_n(input string what, input int exp, input int got);
    checks_done++;
    if (exp != got) begin
      errors++;
      $display("MISMATCH %s exp %0d got %0d", what, exp, got);
    end
  endtask

  task automatic chk_v(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle delimiter pulse; t0 marks its drive edge
  task automatic pulse(input logic is_t);
    line_rx_j <= !is_t;
    line_rx_t <= is_t;
    t0 = cyc + 1;
    tick(1);
    line_rx_j <= 1'b0;
    line_rx_t <= 1'b0;
  endtask

  // 100 Mb/s start strobe, loop carrier off
  task automatic s_tx100;
    tick(6);
    t0 = cyc + 1;
    mac.frame(20, 4'h0);
    tick(20);
    chk_n("j_delay", 13, rise[0] - t0);
    chk_n("j_width", 1, fall[0] - rise[0]);
    chk_v("crs_idle", 8'h0, {7'h0, crs});
  endtask

  // Line delimiters with and without collision
  task automatic s_line100;
    line_collision <= 1'b1;
    tick(4);
    pulse(1'b0);
    tick(40);
    chk_n("crs_on", 17, rise[1] - t0);
    chk_n("col_on", 21, rise[2] - t0);
    pulse(1'b1);
    tick(40);
    chk_n("crs_off", 24, fall[1] - t0);
    chk_n("col_off", 25, fall[2] - t0);
    line_collision <= 1'b0;
    tick(4);
    pulse(1'b0);
    tick(40);
    chk_v("no_col", 8'h2, {6'h0, crs, col});
    pulse(1'b1);
    tick(40);
  endtask

  // Own carrier at both speeds; 10 Mb/s fills and drains the buffer
  task automatic s_loop;
    repeater_mode_select <= 1'b0;
    for (int s = 1; s >= 0; s--) begin
      speed_100 <= (s == 1);
      tick(6);
      saw_full = 1'b0;
      bits.delete();
      t0 = cyc + 1;
      mac.frame(12, 4'h1);
      t1 = cyc + 1;
      tick(60);
      chk_n("loop_on", 7, rise[1] - t0);
      chk_n("loop_off", 7, fall[1] - t1);
      if (s == 0) begin
        chk_n("act_delay", 2, rise[4] - t0);
        chk_v("refused", 8'h1, {7'h0, saw_full});
        chk_v("drained", 8'h1, {7'h0, tx_ready & ~mon[4]});
        chk_n("bit_count", 48, bits.size());
        for (int b = 0; b < 48; b++)
          chk_v("tx_bit", 8'(((b / 4 + 1) >> (b % 4)) & 1),
                {7'h0, bits[b]});
      end
    end
    repeater_mode_select <= 1'b1;
  endtask

  // 10 Mb/s receive, first bit into bit 0
  task automatic s_rx10;
    logic [7:0] pat;
    pat = 8'ha6;
    t0 = cyc + 1;
    for (int b = 0; b < 9; b++) begin
      line_rx_carrier <= 1'b1;
      twisted_pair_rx_in <= pat[b % 8];
      tick(1);
    end
    line_rx_carrier <= 1'b0;
    twisted_pair_rx_in <= 1'b1;
    repeat (3) @(negedge clk);
    chk_v("rxd", {4'h0, pat[7:4]}, {4'h0, rxd});
    chk_n("dv_delay", 6, rise[3] - t0);
    tick(8);
    chk_v("rx_idle", 8'h0, {3'h0, rx_dv, rxd});
  endtask

  // Reset, then scenarios in turn
  initial begin
    rst = 1'b1;
    {speed_100, repeater_mode_select} = 2'b11;
    {line_rx_j, line_rx_t, line_collision, line_rx_carrier} = 4'h0;
    twisted_pair_rx_in = 1'b0;
    saw_full = 1'b0;
    tick(11);
    @(negedge clk);
    chk_v("reset_out", 8'h1, {3'h0, line_tx_j, crs, col, rx_dv, tx_ready});
    @(posedge clk);
    rst <= 1'b0;
    s_tx100();
    s_line100();
    s_loop();
    s_rx10();
    stop_test();
  end
endmodule

`default_nettype wire

// file: verif/phy_mii_line_latency_props.sv
/*
  Latency checker bound to the transceiver timing core.
  Assumes one clock, synchronous active-high reset and straps that
  stay put around each event.
*/
`default_nettype none

module phy_mii_line_latency_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic speed_100,
  input wire logic repeater_mode_select,
  input wire logic tx_en,
  input wire logic tx_ready,
  input wire logic line_rx_j,
  input wire logic line_rx_t,
  input wire logic line_collision,
  input wire logic line_rx_carrier,
  input wire logic line_tx_j,
  input wire logic twisted_pair_tx_active,
  input wire logic crs,
  input wire logic col,
  input wire logic rx_dv
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain for every check
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Loop carrier only counts with the line quiet
  wire logic loop_on;
  assign loop_on = !repeater_mode_select && !line_rx_carrier;

  property p_tx_j;
    $rose(tx_en) && speed_100 |->
      ##12 !line_tx_j ##1 line_tx_j ##1 !line_tx_j;
  endproperty
  a_tx_j: assert property (p_tx_j)
    else $error("line J strobe timing");
  property p_crs_on;
    $rose(line_rx_j) && speed_100 && repeater_mode_select && !crs
      |-> ##16 !crs ##1 crs;
  endproperty
  a_crs_on: assert property (p_crs_on)
    else $error("carrier rise after J");
  property p_crs_off;
    $rose(line_rx_t) && speed_100 && repeater_mode_select && crs
      |-> ##23 crs ##1 !crs;
  endproperty
  a_crs_off: assert property (p_crs_off)
    else $error("carrier fall after T");
  property p_col_on;
    $rose(line_rx_j) && speed_100 && line_collision && !col
      |-> ##20 !col ##1 col;
  endproperty
  a_col_on: assert property (p_col_on)
    else $error("collision rise after J");
  property p_col_off;
    $rose(line_rx_t) && speed_100 && col |-> ##24 col ##1 !col;
  endproperty
  a_col_off: assert property (p_col_off)
    else $error("collision fall after T");
  property p_loop_on;
    $rose(tx_en) && loop_on && !crs |-> ##6 !crs ##1 crs;
  endproperty
  a_loop_on: assert property (p_loop_on)
    else $error("loop carrier rise");
  property p_loop_off;
    $fell(tx_en) && loop_on && crs |-> ##6 crs ##1 !crs;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loop carrier fall");
  property p_tx10;
    !speed_100 && tx_en && tx_ready && !twisted_pair_tx_active
      |-> ##[1:6] twisted_pair_tx_active;
  endproperty
  a_tx10: assert property (p_tx10)
    else $error("serial transmit late");
  property p_rx10;
    !speed_100 && $rose(line_rx_carrier) ##3 line_rx_carrier
      |-> ##[1:7] rx_dv;
  endproperty
  a_rx10: assert property (p_rx10)
    else $error("receive nibble late");
endmodule

bind phy_mii_line_latency phy_mii_line_latency_props u_props (
  .clk, .rst, .speed_100, .repeater_mode_select, .tx_en, .tx_ready,
  .line_rx_j, .line_rx_t, .line_collision, .line_rx_carrier,
  .line_tx_j, .twisted_pair_tx_active, .crs, .col, .rx_dv
);

`default_nettype wire
